// ### hw/bic_map.vh
/*
 constants for the binary io and interlock control block.
 assumes one 100 MHz clock and a synchronous active-high reset.
*/
// Notes on behaviour
// - read and report switching state of up to three switchgear objects.
// - each object status channel is two separate binary inputs.
// - one member gives open position, the other gives closed position.
// - object status shown on 4x4 indicator matrix, user placed, three used.
// - exactly one read object is controllable via open and close outputs.
// - commands come from front buttons locally or serial bus remotely.
// - read six external single channels and four internal protection channels.
// - three internal channels carry start and trip, one carries restart enable.
// - every single channel has a selectable active-high or active-low polarity.
// - external indicators optionally latch; cleared by both buttons or clear param.
// - channel mapped to open or close output gives a pulse when activated.
// - signalling outputs follow their mapped channel for as long as active; in direct mode the direct program also gates them.
// - open or close command first runs the interlocking evaluation.
// - after evaluation the command is executed or discarded.
// - interlocking operands are object status inputs and single channel states.
// - protection trip bypasses interlocking, never blocked or delayed; dropped if a pulse is already running.
// - preset interlocking schemes each tied to a preset object layout.
// - normally open and close outputs driven only by explicit commands.
// - direct output mode drives outputs from inputs and key switch without commands.
`ifndef BIC_MAP_VH
`define BIC_MAP_VH
`define BIC_CLK_MHZ 100
`define BIC_PULSE_MS 100
`define BIC_PULSE_CYC (`BIC_PULSE_MS * 1000 * `BIC_CLK_MHZ)
`define BIC_NUM_OBJ 3
`define BIC_NUM_EXT 6
`define BIC_NUM_INT 4
`define BIC_NUM_CH 10
`define BIC_ST_UNDEF_LO 2'h0
`define BIC_ST_OPEN 2'h1
`define BIC_ST_CLOSED 2'h2
`define BIC_ST_UNDEF_HI 2'h3
`define BIC_CMD_NONE 2'h0
`define BIC_CMD_OPEN 2'h1
`define BIC_CMD_CLOSE 2'h2
`define BIC_NUM_SCHEMES 4
`define BIC_SETTLE_CYC 3'h5
`endif

// ### hw/bic_sync.v
/*
 three flip-flop synchroniser for a bus of pin inputs.
 assumes the pins are asynchronous to i_clk; a change counts when stages two and three agree.
*/
`timescale 1ns/100ps
module bic_sync #(
   parameter W = 8
) (
   input wire i_clk,
   input wire i_srst,
   input wire [W-1:0] i_pin,
   output reg [W-1:0] o_val
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   always @(posedge i_clk) begin
      if (i_srst) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         o_val <= {W{1'b0}};
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // bitwise: only agreed bits update
         o_val <= (s2_q & s3_q) | (o_val & (s2_q | s3_q));
      end
   end
endmodule // bic_sync

// ### hw/bic_pulse.v
/*
 fixed-length open/close pulse generator with mutual exclusion.
 assumes one clock; start requests are single-cycle pulses or, in direct mode, held levels that restart the pulse.
*/
`timescale 1ns/100ps
module bic_pulse #(
   parameter CYC = 10000000
) (
   input wire i_clk,
   input wire i_srst,
   input wire i_open,
   input wire i_close,
   output reg o_open,
   output reg o_close,
   output wire o_busy
);
   reg [31:0] cnt_q;
   assign o_busy = o_open | o_close;
   always @(posedge i_clk) begin
      if (i_srst) begin
         cnt_q <= 32'h00000000;
         o_open <= 1'b0;
         o_close <= 1'b0;
      end else if (o_busy) begin
         if (cnt_q == 32'h00000001) begin
            o_open <= 1'b0;
            o_close <= 1'b0;
         end
         cnt_q <= cnt_q - 32'h00000001;
      end else if (i_open) begin
         // open wins a tie: opening is the safe direction
         o_open <= 1'b1;
         cnt_q <= CYC;
      end else if (i_close) begin
         o_close <= 1'b1;
         cnt_q <= CYC;
      end
   end
endmodule // bic_pulse

// ### hw/bic_top.v
/*
 binary io and interlock control: object status, single channels, indicators,
 interlocked open/close commands, signalling outputs and direct output mode.
 assumes pins arrive asynchronously; command strobes and settings are on i_clk.
*/
`timescale 1ns/100ps
`include "bic_map.vh"
module bic_top #(
   parameter PULSE_CYC = `BIC_PULSE_CYC,
   parameter CTRL_OBJ = 0
) (
   input wire i_clk,
   input wire i_srst,
   input wire [5:0] i_obj_pins,
   input wire [5:0] i_ext_pins,
   input wire [3:0] i_int_sig,
   input wire i_key_remote,
   input wire i_btn_step,
   input wire i_btn_select,
   input wire i_loc_open,
   input wire i_loc_close,
   input wire i_rem_open,
   input wire i_rem_close,
   input wire [9:0] i_ch_pol_high,
   input wire [5:0] i_ext_latch_en,
   input wire i_clr_param_wr,
   input wire [7:0] i_clr_param_val,
   input wire [9:0] i_ch_to_open,
   input wire [9:0] i_ch_to_close,
   input wire [9:0] i_ch_to_sig1,
   input wire [9:0] i_ch_to_sig2,
   input wire [9:0] i_ch_to_sig3,
   input wire [1:0] i_scheme,
   input wire i_user_ilk_en,
   input wire [15:0] i_user_open_need,
   input wire [15:0] i_user_open_val,
   input wire [15:0] i_user_close_need,
   input wire [15:0] i_user_close_val,
   input wire i_direct_mode,
   input wire [15:0] i_dir_open_need,
   input wire [15:0] i_dir_open_val,
   input wire [15:0] i_dir_close_need,
   input wire [15:0] i_dir_close_val,
   input wire [15:0] i_dir_sig_need,
   input wire [15:0] i_dir_sig_val,
   input wire [3:0] i_led_pos0,
   input wire [3:0] i_led_pos1,
   input wire [3:0] i_led_pos2,
   output reg [5:0] o_obj_state,
   output reg [2:0] o_obj_undef,
   output reg [15:0] o_led_open,
   output reg [15:0] o_led_closed,
   output reg [9:0] o_ch_active,
   output reg [5:0] o_ext_led,
   output reg o_open,
   output reg o_close,
   output reg [2:0] o_signal,
   output reg o_cmd_done,
   output reg o_cmd_cancel
);
   localparam ST_IDLE = 2'h0;
   localparam ST_EVAL = 2'h1;
   localparam ST_EXEC = 2'h2;

   wire [5:0] obj_s;
   wire [5:0] ext_s;
   wire [3:0] int_s;
   wire [1:0] btn_s;
   wire key_s;
   wire p_open;
   wire p_close;
   wire p_busy;

   reg [1:0] st_q;
   reg [1:0] st_d;
   reg [1:0] cmd_q;
   reg [1:0] cmd_d;
   reg ok_q;
   reg ok_d;
   reg [9:0] ch_prev_q;
   reg [5:0] ext_lat_q;
   reg [1:0] btn_prev_q;
   reg trip_req;
   reg ilk_open_req;
   reg ilk_close_req;
   reg [9:0] ch_act;
   reg [15:0] opnd;
   reg ok_open;
   reg ok_close;
   reg sch_open;
   reg sch_close;
   reg [9:0] rise;
   reg dir_open;
   reg dir_close;
   reg [2:0] sig_d;
   reg [15:0] led_o_d;
   reg [15:0] led_c_d;
   reg clr_ev;
   reg [5:0] ext_lat_d;
   reg btn_both;
   reg param_clr;
   reg want_open;
   reg want_close;
   reg [15:0] dopnd;
   reg [2:0] sig_map;
   reg sig_gate;
   reg [1:0] st0;
   reg [1:0] st1;
   reg [1:0] st2;
   reg [2:0] settle_q;
   reg settled;
   reg [9:0] rise_mask;

   function match;
      input [15:0] need;
      input [15:0] val;
      input [15:0] x;
      begin
         match = ((x ^ val) & need) == 16'h0000;
      end
   endfunction

   function [1:0] obj_st;
      input [1:0] pair;
      begin
         // pair[0] open member, pair[1] closed member
         obj_st = pair;
      end
   endfunction

   function [15:0] pos_bit;
      input [3:0] pos;
      begin
         pos_bit = 16'h0001 << pos;
      end
   endfunction

   // both or neither contact: travelling or broken wiring
   function is_undef;
      input [1:0] st;
      begin
         is_undef = (st == `BIC_ST_UNDEF_LO) || (st == `BIC_ST_UNDEF_HI);
      end
   endfunction

   // one bank of stages for every pin so they share timing
   bic_sync #(
      .W(15)
   ) u_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_pin({i_key_remote, i_btn_select, i_btn_step, i_ext_pins, i_obj_pins}),
      .o_val({key_s, btn_s, ext_s, obj_s})
   );

   // internal channels come from logic on i_clk, so no synchroniser
   assign int_s = i_int_sig;

   always @* begin
      // polarity per channel, external then internal
      ch_act = {int_s, ext_s} ~^ i_ch_pol_high;
      // operands: six status bits, ten channel states
      opnd = {ch_act, obj_s};
      // sync stages hold zeros after reset; external edges wait until they carry pins
      settled = (settle_q == `BIC_SETTLE_CYC);
      rise_mask = {4'hF, {6{settled}}};
      rise = ch_act & ~ch_prev_q & rise_mask;
      st0 = obj_st(obj_s[1:0]);
      st1 = obj_st(obj_s[3:2]);
      st2 = obj_st(obj_s[5:4]);
      dopnd = {opnd[15:1], key_s};
      // scheme selects layout-matched fixed interlocks on the controlled object
      case (i_scheme)
         2'h0: begin
            sch_open = 1'b1;
            sch_close = 1'b1;
         end
         2'h1: begin
            // close only if objects 1 and 2 (disconnectors) are closed
            sch_open = 1'b1;
            sch_close = (obj_st(obj_s[3:2]) == `BIC_ST_CLOSED) &&
                        (obj_st(obj_s[5:4]) == `BIC_ST_CLOSED);
         end
         2'h2: begin
            // close blocked while restart enable is absent
            sch_open = 1'b1;
            sch_close = ch_act[7];
         end
         default: begin
            sch_open = 1'b1;
            sch_close = (obj_st(obj_s[3:2]) == `BIC_ST_CLOSED) && ch_act[7];
         end
      endcase
      ok_open = i_user_ilk_en ? match(i_user_open_need, i_user_open_val, opnd) : sch_open;
      ok_close = i_user_ilk_en ? match(i_user_close_need, i_user_close_val, opnd) : sch_close;
      dir_open = match(i_dir_open_need, i_dir_open_val, dopnd) &
                 (i_dir_open_need != 16'h0000);
      dir_close = match(i_dir_close_need, i_dir_close_val, dopnd) &
                  (i_dir_close_need != 16'h0000);
      // protection trip channels are internal channels 0 and 2 (bits 6 and 8)
      trip_req = |(rise & i_ch_to_open & 10'h140);
      ilk_open_req = |(rise & i_ch_to_open & ~10'h140);
      ilk_close_req = |(rise & i_ch_to_close);
      btn_both = (btn_s == 2'h3) && (btn_prev_q != 2'h3);
      param_clr = i_clr_param_wr && (i_clr_param_val <= 8'h01);
      clr_ev = btn_both || param_clr;
      ext_lat_d = ((clr_ev ? 6'h00 : ext_lat_q) | ch_act[5:0]) & i_ext_latch_en;
      led_o_d = 16'h0000;
      led_c_d = 16'h0000;
      if (obj_s[0] & ~obj_s[1]) led_o_d = led_o_d | pos_bit(i_led_pos0);
      if (obj_s[1] & ~obj_s[0]) led_c_d = led_c_d | pos_bit(i_led_pos0);
      if (obj_s[2] & ~obj_s[3]) led_o_d = led_o_d | pos_bit(i_led_pos1);
      if (obj_s[3] & ~obj_s[2]) led_c_d = led_c_d | pos_bit(i_led_pos1);
      if (obj_s[4] & ~obj_s[5]) led_o_d = led_o_d | pos_bit(i_led_pos2);
      if (obj_s[5] & ~obj_s[4]) led_c_d = led_c_d | pos_bit(i_led_pos2);
      sig_map = {|(ch_act & i_ch_to_sig3), |(ch_act & i_ch_to_sig2),
                 |(ch_act & i_ch_to_sig1)};
      sig_gate = match(i_dir_sig_need, i_dir_sig_val, dopnd);
      if (i_direct_mode) begin
         // each signalling output is also gated by the direct program
         sig_d = sig_map & {3{sig_gate}};
      end else begin
         sig_d = sig_map;
      end
      // key read through the synchroniser so a pin edge cannot split the choice
      want_open = key_s ? i_rem_open : i_loc_open;
      want_close = key_s ? i_rem_close : i_loc_close;
   end

   // command sequencer: take, evaluate, execute or cancel
   always @* begin
      st_d = st_q;
      cmd_d = cmd_q;
      ok_d = ok_q;
      case (st_q)
         ST_IDLE: begin
            if (!i_direct_mode) begin
               // mapped channel edges lose to front and serial commands and are not kept
               if (want_open) begin
                  cmd_d = `BIC_CMD_OPEN;
                  st_d = ST_EVAL;
               end else if (want_close) begin
                  cmd_d = `BIC_CMD_CLOSE;
                  st_d = ST_EVAL;
               end else if (ilk_open_req) begin
                  cmd_d = `BIC_CMD_OPEN;
                  st_d = ST_EVAL;
               end else if (ilk_close_req) begin
                  cmd_d = `BIC_CMD_CLOSE;
                  st_d = ST_EVAL;
               end
            end
         end
         ST_EVAL: begin
            ok_d = (cmd_q == `BIC_CMD_OPEN) ? ok_open : ok_close;
            st_d = ST_EXEC;
         end
         ST_EXEC: begin
            st_d = ST_IDLE;
            cmd_d = `BIC_CMD_NONE;
         end
         default: begin
            st_d = ST_IDLE;
            cmd_d = `BIC_CMD_NONE;
         end
      endcase
   end

   // trip reaches the pulse generator directly; interlocked commands only after eval
   wire pulse_open_req = trip_req ||
      (st_q == ST_EXEC && ok_q && cmd_q == `BIC_CMD_OPEN) ||
      (i_direct_mode && dir_open);
   wire pulse_close_req = (st_q == ST_EXEC && ok_q && cmd_q == `BIC_CMD_CLOSE) ||
      (i_direct_mode && dir_close);

   bic_pulse #(
      .CYC(PULSE_CYC)
   ) u_pulse (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_open(pulse_open_req),
      .i_close(pulse_close_req),
      .o_open(p_open),
      .o_close(p_close),
      .o_busy(p_busy)
   );

   // status side: pins to indicators, plus the channel edge and settle registers that feed command requests
   always @(posedge i_clk) begin
      if (i_srst) begin
         ch_prev_q <= 10'h000;
         ext_lat_q <= 6'h00;
         btn_prev_q <= 2'h0;
         settle_q <= 3'h0;
         o_obj_state <= 6'h00;
         o_obj_undef <= 3'h0;
         o_led_open <= 16'h0000;
         o_led_closed <= 16'h0000;
         o_ch_active <= 10'h000;
         o_ext_led <= 6'h00;
         o_signal <= 3'h0;
      end else begin
         ch_prev_q <= ch_act;
         btn_prev_q <= btn_s;
         if (settle_q != `BIC_SETTLE_CYC) begin
            settle_q <= settle_q + 3'h1;
         end
         o_obj_state <= obj_s;
         o_obj_undef[0] <= is_undef(st0);
         o_obj_undef[1] <= is_undef(st1);
         o_obj_undef[2] <= is_undef(st2);
         o_led_open <= led_o_d;
         o_led_closed <= led_c_d;
         o_ch_active <= ch_act;
         // new activity wins over a clear in the same cycle
         ext_lat_q <= ext_lat_d;
         o_ext_led <= ch_act[5:0] | ext_lat_d;
         o_signal <= sig_d;
      end
   end

   // command side: sequencer state and pulse outputs
   always @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= ST_IDLE;
         cmd_q <= `BIC_CMD_NONE;
         ok_q <= 1'b0;
         o_open <= 1'b0;
         o_close <= 1'b0;
         o_cmd_done <= 1'b0;
         o_cmd_cancel <= 1'b0;
      end else begin
         st_q <= st_d;
         cmd_q <= cmd_d;
         ok_q <= ok_d;
         o_open <= p_open;
         o_close <= p_close;
         o_cmd_done <= (st_q == ST_EXEC) && ok_q;
         o_cmd_cancel <= (st_q == ST_EXEC) && !ok_q;
      end
   end
endmodule // bic_top

// ### sim/bic_monitor.sv
/*
 checker of bic_top port behaviour, bound to every bic_top instance.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module bic_monitor #(
   parameter PULSE_CYC = 8
) (
   input wire i_clk,
   input wire i_srst,
   input wire [5:0] i_obj_pins,
   input wire [3:0] i_int_sig,
   input wire i_key_remote,
   input wire i_loc_open,
   input wire i_loc_close,
   input wire i_rem_open,
   input wire i_rem_close,
   input wire [9:0] i_ch_pol_high,
   input wire [9:0] i_ch_to_open,
   input wire [9:0] i_ch_to_close,
   input wire i_direct_mode,
   input wire [5:0] o_obj_state,
   input wire [2:0] o_obj_undef,
   input wire o_open,
   input wire o_close,
   input wire o_cmd_done,
   input wire o_cmd_cancel
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // quiet count: a mapped channel or direct mode may also move the outputs
   wire busy_in = i_loc_open | i_loc_close | i_rem_open | i_rem_close | i_direct_mode
      | (|i_ch_to_open) | (|i_ch_to_close);
   wire cmd_in = i_key_remote ? (i_rem_open | i_rem_close) : (i_loc_open | i_loc_close);
   wire open_in = i_key_remote ? i_rem_open : i_loc_open;
   reg [3:0] quiet_q;
   reg [31:0] wide_q;
   reg dir_q;
   always @(posedge i_clk) begin
      quiet_q <= (i_srst | busy_in) ? 4'h0 : (quiet_q == 4'hF ? quiet_q : quiet_q + 4'h1);
      wide_q <= (i_srst | ~o_open) ? 32'h0 : wide_q + 32'h1;
      dir_q <= i_srst ? 1'b0 : (dir_q | i_direct_mode);
   end
   sequence s_take;
      quiet_q >= 4'h3 && !i_direct_mode && !o_open && !o_close && cmd_in;
   endsequence
   sequence s_pins_still;
      $stable(i_obj_pins) [*6];
   endsequence
   a_out_excl: assert property (!(o_open && o_close))
      else $error("open and close outputs high together");
   a_pulse_width: assert property ($fell(o_open) && !dir_q |-> wide_q == PULSE_CYC)
      else $error("open pulse length wrong");
   a_cmd_answer: assert property (s_take |-> ##3 (o_cmd_done ^ o_cmd_cancel))
      else $error("command not answered on time");
   a_done_drives: assert property (s_take ##0 open_in ##3 o_cmd_done |-> ##[0:1] o_open)
      else $error("accepted open gave no pulse");
   a_cancel_quiet: assert property (s_take ##3 o_cmd_cancel |-> !(o_open | o_close) [*2])
      else $error("cancelled command drove an output");
   a_no_spont: assert property (quiet_q >= 4'h6 |-> !$rose(o_open) && !$rose(o_close))
      else $error("output without a command");
   a_obj_state: assert property (s_pins_still |-> o_obj_state == i_obj_pins)
      else $error("object state differs from pins");
   a_obj_undef: assert property (s_pins_still |-> o_obj_undef == {i_obj_pins[5] ~^ i_obj_pins[4],
      i_obj_pins[3] ~^ i_obj_pins[2], i_obj_pins[1] ~^ i_obj_pins[0]})
      else $error("undefined flag wrong");
   a_trip_bypass: assert property ($rose(i_int_sig[0]) && i_ch_pol_high[6] && i_ch_to_open[6]
      && !o_open && !o_close && !i_direct_mode |-> ##[1:3] o_open)
      else $error("trip did not reach open output");
endmodule // bic_monitor
bind bic_top bic_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.*);

// ### sim/bic_gear.sv
/*
 switchgear model: controlled object plus two read-only objects.
 assumes open/close pulses from the block on the same clock.
*/
`timescale 1ns/100ps
module bic_gear (
   input wire i_clk,
   input wire i_srst,
   input wire i_open,
   input wire i_close,
   input wire [3:0] i_far,
   output wire [5:0] o_pins
);
   reg [1:0] pos_q;
   reg [1:0] goal_q;
   // contacts read 00 while travelling, as a real breaker mid-stroke
   always @(posedge i_clk) begin
      if (i_srst) begin
         pos_q <= 2'h1;
         goal_q <= 2'h1;
      end else if (i_open | i_close) begin
         pos_q <= 2'h0;
         goal_q <= i_open ? 2'h1 : 2'h2;
      end else if (pos_q == 2'h0) begin
         pos_q <= goal_q;
      end
   end
   assign o_pins = {i_far, pos_q};
endmodule // bic_gear

// ### sim/bic_top_tb.sv
/*
 testbench of bic_top with the switchgear model.
 assumes PULSE_CYC set to 8 and a 100 MHz clock.
*/
`timescale 1ns/100ps
module bic_top_tb;
   reg i_clk, i_srst, i_key_remote, i_btn_step, i_btn_select, i_loc_open, i_loc_close;
   reg i_rem_open, i_rem_close, i_clr_param_wr, i_user_ilk_en, i_direct_mode;
   reg [5:0] i_ext_pins, i_ext_latch_en;
   reg [3:0] i_int_sig, far;
   reg [9:0] i_ch_pol_high, i_ch_to_open, i_ch_to_close, i_ch_to_sig1;
   reg [7:0] i_clr_param_val;
   reg [1:0] i_scheme;
   reg [15:0] i_user_open_need, i_user_open_val, i_dir_open_need, i_dir_open_val;
   reg [11:0] lp;
   reg [15:0] dsn;
   wire [5:0] i_obj_pins, o_obj_state, o_ext_led;
   wire [2:0] o_obj_undef, o_signal;
   wire [15:0] o_led_open, o_led_closed;
   wire [9:0] o_ch_active;
   wire o_open, o_close, o_cmd_done, o_cmd_cancel;
   integer n_mismatch, comparisons, v;
   bic_top #(.PULSE_CYC(8)) dut (.*, .i_ch_to_sig2(i_ch_to_sig1), .i_ch_to_sig3(10'h000),
      .i_user_close_need(i_user_open_need), .i_user_close_val(i_user_open_val),
      .i_dir_close_need(16'h0000), .i_dir_close_val(16'h0000), .i_dir_sig_need(dsn),
      .i_dir_sig_val(dsn), .i_led_pos0(lp[3:0]), .i_led_pos1(lp[7:4]),
      .i_led_pos2(lp[11:8]));
   bic_gear gear (.i_clk(i_clk), .i_srst(i_srst), .i_open(o_open), .i_close(o_close),
      .i_far(far), .o_pins(i_obj_pins));
   task chk(input [79:0] nm, input [15:0] seen, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge i_clk);
   endtask
   // fixed window long enough for answer, pulse start and full pulse
   task watch(input [1:0] e, input [1:0] p);
      integer k, n;
      reg [1:0] a, s;
      begin
         a = 2'h0;
         s = 2'h0;
         n = 0;
         for (k = 0; k < 16; k = k + 1) begin
            a = a | {o_cmd_cancel, o_cmd_done};
            s = s | {o_close, o_open};
            n = n + (o_open | o_close);
            cyc(1);
         end
         chk("outputs", {14'h0, s}, {14'h0, p});
         if (e != 2'h3) begin
            chk("answer", {14'h0, a}, {14'h0, e});
            if (p != 2'h0) chk("width", n[15:0], 16'h0008);
         end
      end
   endtask
   task run(input [3:0] c, input [1:0] e, input [1:0] p);
      begin
         {i_rem_close, i_rem_open, i_loc_close, i_loc_open} = c;
         cyc(1);
         {i_rem_close, i_rem_open, i_loc_close, i_loc_open} = 4'h0;
         watch(e, p);
      end
   endtask
   task complete_run;
      begin
         if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      {i_key_remote, i_btn_step, i_btn_select, i_loc_open, i_loc_close, i_rem_open} = 6'h00;
      {i_rem_close, i_clr_param_wr, i_user_ilk_en, i_direct_mode, i_scheme} = 6'h00;
      {i_ext_pins, i_ext_latch_en, i_int_sig, i_clr_param_val} = 24'h000000;
      {i_ch_to_open, i_ch_to_close, i_ch_to_sig1} = 30'h0;
      {i_user_open_need, i_user_open_val, i_dir_open_need, i_dir_open_val} = 64'h0;
      i_ch_pol_high = 10'h3FF;
      far = 4'hE;
      lp = 12'hF05;
      dsn = 16'h0000;
      n_mismatch = 0;
      comparisons = 0;
      i_srst = 1'b1;
      cyc(6);
      i_srst = 1'b0;
      chk("rst_out", {o_open, o_close, o_signal}, 16'h0000);
      cyc(6);
      chk("obj_state", o_obj_state, 16'h0039);
      chk("obj_undef", o_obj_undef, 16'h0004);
      chk("led_mtx", {o_led_open[5], o_led_closed[0]}, 16'h0003);
      run(4'h3, 2'h1, 2'h1);
      run(4'h2, 2'h1, 2'h2);
      cyc(6);
      chk("obj0", o_obj_state[1:0], 16'h0002);
      run(4'h1, 2'h1, 2'h1);
      i_scheme = 2'h1;
      run(4'h2, 2'h2, 2'h0);
      far = 4'hA;
      cyc(6);
      run(4'h2, 2'h1, 2'h2);
      i_scheme = 2'h0;
      i_key_remote = 1'b1;
      cyc(6);
      run(4'h1, 2'h0, 2'h0);
      run(4'h4, 2'h1, 2'h1);
      i_key_remote = 1'b0;
      cyc(6);
      i_user_ilk_en = 1'b1;
      i_user_open_need = 16'h8000;
      i_user_open_val = 16'h8000;
      run(4'h1, 2'h2, 2'h0);
      i_ch_to_open = 10'h040;
      cyc(1);
      i_int_sig[0] = 1'b1;
      watch(2'h3, 2'h1);
      i_int_sig[0] = 1'b0;
      i_ch_to_open = 10'h000;
      i_int_sig[3] = 1'b1;
      cyc(6);
      run(4'h2, 2'h1, 2'h2);
      i_ch_pol_high[0] = 1'b0;
      i_ch_to_sig1 = 10'h001;
      cyc(6);
      chk("act_low", {o_ch_active[0], o_signal[0]}, 16'h0003);
      i_ext_pins[0] = 1'b1;
      cyc(6);
      chk("sig_off", {o_ch_active[0], o_signal[0]}, 16'h0000);
      i_ch_to_close = 10'h002;
      i_ext_pins[1] = 1'b1;
      watch(2'h3, 2'h2);
      i_ch_to_close = 10'h000;
      i_ext_latch_en = 6'h02;
      // value 2 must leave the latch set, 0 and 1 clear it
      for (v = 0; v < 3; v = v + 1) begin
         i_ext_pins[1] = 1'b1;
         cyc(6);
         i_ext_pins[1] = 1'b0;
         cyc(6);
         chk("latched", o_ext_led[1], 16'h0001);
         i_clr_param_val = v[7:0];
         i_clr_param_wr = 1'b1;
         cyc(1);
         i_clr_param_wr = 1'b0;
         cyc(2);
         chk("clr_par", o_ext_led[1], {15'h0, v == 2});
      end
      {i_btn_step, i_btn_select} = 2'h3;
      cyc(6);
      {i_btn_step, i_btn_select} = 2'h0;
      cyc(2);
      chk("clr_btn", o_ext_led[1], 16'h0000);
      i_dir_open_need = 16'h0001;
      i_dir_open_val = 16'h0001;
      i_direct_mode = 1'b1;
      watch(2'h3, 2'h0);
      i_key_remote = 1'b1;
      watch(2'h3, 2'h1);
      dsn = 16'h0001;
      i_ext_pins[0] = 1'b0;
      cyc(6);
      chk("dir_sig", o_signal[0], 16'h0001);
      i_key_remote = 1'b0;
      cyc(6);
      chk("dir_gate", o_signal[0], 16'h0000);
      complete_run;
   end
endmodule // bic_top_tb
